/* hw/adc_out_defs.svh */
`ifndef ADC_OUT_DEFS_SVH
`define ADC_OUT_DEFS_SVH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STAT    12'h008
`define OFS_IRQ_MASK    12'h00c
`define OFS_SAMPLE      12'h010

// control fields
`define CTRL_MODE_LSB   0
`define CTRL_PD_BIT     2
`define CTRL_OEN_BIT    3
`define CTRL_RESET      32'h0000_0008

// status / interrupt fields
`define ST_VALID_BIT    0
`define ST_RANGE_BIT    1
`define ST_WAKE_BIT     2
`define ST_DCS_BIT      3
`define IRQ_NONE        4'h0

// sample word codes
`define CODE_MID        14'h2000
`define CODE_POS_FS     14'h3fff
`define CODE_NEG_FS     14'h0000

// timing
`define CLK_PERIOD_NS   100
`define RELOCK_CYCLES   100
`define NAP_WAKE_CYCLES 100
`define SLEEP_WAKE_MS   2
`define SLEEP_WAKE_CYC  ((`SLEEP_WAKE_MS * 1000000) / `CLK_PERIOD_NS)
`define PD_PULSE_NS     1000
`define PD_PULSE_CYC    ((`PD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hw/adc_out_pkg.sv */
package adc_out_pkg;

  // four-level configuration pin state
  typedef enum logic [1:0] {
    MODE_GND,
    MODE_THIRD,
    MODE_TWO_THIRD,
    MODE_SUPPLY
  } mode_level_e;

  // operating state
  typedef enum logic [1:0] {
    OP_NORMAL,
    OP_NAP,
    OP_SLEEP
  } op_mode_e;

  typedef logic [13:0] sample_t;

endpackage : adc_out_pkg

/* hw/recovery_if.sv */
interface recovery_if;
  logic        start;
  logic [31:0] cycles;
  logic        busy;
  logic        done;

  modport ctrl (output start, output cycles, input busy, input done);
  modport timer (input start, input cycles, output busy, output done);
endinterface : recovery_if

/* hw/recovery_timer.sv */
`include "adc_out_defs.svh"

module recovery_timer
  import adc_out_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  recovery_if.timer rec
);

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic        done_ff;
  logic        nxt_done;

  // a new start reloads the wait with its own cycle count, so a shorter second request can cut a longer wait short
  always_comb begin
    nxt_count = count_ff;
    nxt_done  = 1'b0;
    if (rec.start) begin
      nxt_count = rec.cycles;
    end else if (count_ff != 32'h0) begin
      nxt_count = count_ff - 32'h1;
      nxt_done  = (count_ff == 32'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 32'h0;
      done_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

  assign rec.busy = (count_ff != 32'h0);
  assign rec.done = done_ff;

endmodule : recovery_timer

/* hw/sample_pipe.sv */
`include "adc_out_defs.svh"

module sample_pipe
  import adc_out_pkg::*;
#(
  parameter int LATENCY = 5
) (
  // clock and reset
  input  wire logic    pclk,
  input  wire logic    presetn,
  // input side
  input  wire sample_t din,
  input  wire logic    flag_in,
  // output side
  output sample_t      dout,
  output logic         flag_out
);

  sample_t stage_ff [LATENCY];
  logic    flag_ff  [LATENCY];

  // word and flag share every stage, so they can never slip apart
  genvar i;
  generate
    for (i = 0; i < LATENCY; i++) begin : g_stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_ff[i] <= `CODE_MID;
          flag_ff[i]  <= 1'b0;
        end else if (i == 0) begin
          stage_ff[i] <= din;
          flag_ff[i]  <= flag_in;
        end else begin
          stage_ff[i] <= stage_ff[(i == 0) ? 0 : i - 1];
          flag_ff[i]  <= flag_ff[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign dout     = stage_ff[LATENCY-1];
  assign flag_out = flag_ff[LATENCY-1];

endmodule : sample_pipe

/* hw/adc_out_ctrl.sv */
// Function
// - stabilizer on: sample on rising edge, falling edge ignored, internal 50 percent.
// - stabilizer needs about 100 cycles to relock; output invalid until then.
// - offset binary: mid code 2000h, all ones positive, all zeros negative.
// - two's complement is offset binary with top bit inverted.
// - out of range raises flag and clamps word to full scale.
// - ground and one-third select offset binary; upper levels two's complement.
// - stabilizer on at one-third and two-thirds levels, off otherwise.
// - output-drive control high disables sample word and flag.
// - power-down low means normal conversion.
// - power-down and drive control high: sleep; data invalid for milliseconds after.
// - power-down high, drive control low: nap; data valid 100 cycles after.
// - in sleep and nap all digital outputs are high impedance; here out_enable releases word and flag only, data_valid is held low.
// - each rising clock edge takes one sample.
`include "adc_out_defs.svh"

module adc_out_ctrl
  import adc_out_pkg::*;
#(
  parameter int LATENCY        = 5,
  parameter int SLEEP_WAKE_CYC = `SLEEP_WAKE_CYC
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // converter core result, one per clock
  input  wire logic [14:0] core_value,
  input  wire logic        core_over,
  input  wire logic        core_under,
  // parallel output pins
  output logic [13:0]      sample_word,
  output logic             range_exceeded_flag,
  output logic             out_enable,
  output logic             data_valid,
  output logic             internal_clk_half,
  // interrupt
  output logic             irq
);

  logic [31:0] ctrl_ff,   nxt_ctrl;
  logic [3:0]  istat_ff,  nxt_istat;
  logic [3:0]  imask_ff,  nxt_imask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pslverr_ff, nxt_pslverr;
  op_mode_e    op_ff,     nxt_op;
  logic        valid_ff,  nxt_valid;
  logic        wake_pend_ff, nxt_wake_pend;
  logic        half_ff,   nxt_half;
  logic [13:0] word_ff,   nxt_word;
  logic        flag_ff,   nxt_flag;
  logic        dcs_prev_ff;
  logic        range_prev_ff;

  mode_level_e mode_lvl;
  logic        fmt_twos;
  logic        dcs_on;
  logic        pd_req;
  logic        drive_off_n;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_word;
  logic        addr_hit;
  sample_t     clamp_word;
  sample_t     pipe_word;
  logic        pipe_flag;
  logic        ev_valid;
  logic        ev_range;
  logic        ev_wake;
  logic        ev_dcs;

  recovery_if rec ();

  // configuration decode
  assign mode_lvl    = mode_level_e'(ctrl_ff[`CTRL_MODE_LSB +: 2]);
  assign pd_req      = ctrl_ff[`CTRL_PD_BIT];
  assign drive_off_n = ctrl_ff[`CTRL_OEN_BIT];

  function automatic logic is_twos(input mode_level_e m);
    is_twos = (m == MODE_TWO_THIRD) || (m == MODE_SUPPLY);
  endfunction : is_twos

  function automatic logic is_dcs(input mode_level_e m);
    is_dcs = (m == MODE_THIRD) || (m == MODE_TWO_THIRD);
  endfunction : is_dcs

  assign fmt_twos = is_twos(mode_lvl);
  assign dcs_on   = is_dcs(mode_lvl);

  // apb decode; always ready in one access cycle
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // clamp raw core value, one sample per edge
  always_comb begin
    clamp_word = core_value[13:0];
    if (core_over) begin
      clamp_word = `CODE_POS_FS;
    end else if (core_under) begin
      clamp_word = `CODE_NEG_FS;
    end
  end

  // fixed latency keeps word and flag aligned
  sample_pipe #(
    .LATENCY (LATENCY)
  ) u_pipe (
    .pclk     (pclk),
    .presetn  (presetn),
    .din      (clamp_word),
    .flag_in  (core_over || core_under),
    .dout     (pipe_word),
    .flag_out (pipe_flag)
  );

  recovery_timer u_rec (
    .pclk    (pclk),
    .presetn (presetn),
    .rec     (rec)
  );

  // operating mode and recovery control
  always_comb begin
    nxt_op        = op_ff;
    nxt_valid     = valid_ff;
    nxt_wake_pend = 1'b0;
    rec.start     = 1'b0;
    rec.cycles    = 32'h0;
    case (op_ff)
      OP_NORMAL: begin
        if (pd_req && drive_off_n) begin
          nxt_op    = OP_SLEEP;
          nxt_valid = 1'b0;
        end else if (pd_req) begin
          nxt_op    = OP_NAP;
          nxt_valid = 1'b0;
        end
      end
      OP_NAP, OP_SLEEP: begin
        if (!pd_req) begin
          nxt_op     = OP_NORMAL;
          rec.start  = 1'b1;
          rec.cycles = (op_ff == OP_SLEEP) ? 32'(SLEEP_WAKE_CYC)
                                           : 32'(`NAP_WAKE_CYCLES);
        end else if (drive_off_n) begin
          nxt_op = OP_SLEEP;
        end else begin
          nxt_op = OP_NAP;
        end
      end
      default: begin
        nxt_op = OP_NORMAL;
      end
    endcase
    // stabilizer turned on: relock before data counts again
    if (dcs_on && !dcs_prev_ff && !rec.start) begin
      rec.start  = 1'b1;
      rec.cycles = 32'(`RELOCK_CYCLES);
      nxt_valid  = 1'b0;
    end
    if (rec.start) begin
      nxt_valid = 1'b0;
    end else if (rec.done && op_ff == OP_NORMAL) begin
      nxt_valid     = 1'b1;
      nxt_wake_pend = 1'b1;
    end
  end

  // internal half-clock: with stabilizer it toggles every edge for an even duty
  always_comb begin
    nxt_half = 1'b0;
    if (dcs_on) begin
      nxt_half = !half_ff;
    end
  end

  // output stage registers word and flag together
  always_comb begin
    nxt_word = word_ff;
    nxt_flag = flag_ff;
    if (op_ff == OP_NORMAL) begin
      nxt_word = fmt_twos ? {~pipe_word[13], pipe_word[12:0]} : pipe_word;
      nxt_flag = pipe_flag;
    end
  end

  // event capture; set wins over read clear
  assign ev_valid = wake_pend_ff;
  assign ev_range = pipe_flag && !range_prev_ff;
  assign ev_wake  = rec.start;
  assign ev_dcs   = dcs_on && !dcs_prev_ff;

  // register file; read data and error are loaded at the setup edge so that
  // they already stand at the access edge, where the master takes them
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_imask   = imask_ff;
    nxt_istat   = istat_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = psel ? pslverr_ff : 1'b0;
    rd_word     = 32'h0;
    addr_hit    = 1'b1;
    case (paddr)
      `OFS_CTRL:     rd_word = ctrl_ff;
      `OFS_STATUS:   rd_word = {26'h0, op_ff, dcs_on, rec.busy, flag_ff, valid_ff};
      `OFS_IRQ_STAT: rd_word = {28'h0, istat_ff};
      `OFS_IRQ_MASK: rd_word = {28'h0, imask_ff};
      `OFS_SAMPLE:   rd_word = {17'h0, flag_ff, word_ff};
      default:       addr_hit = 1'b0;
    endcase
    if (psel && !penable) begin
      nxt_pslverr = !addr_hit;
      if (!pwrite) begin
        nxt_prdata = rd_word;
      end
    end
    if (wr_en) begin
      case (paddr)
        `OFS_CTRL:     nxt_ctrl  = {28'h0, pwdata[3:0]};
        `OFS_IRQ_MASK: nxt_imask = pwdata[3:0];
        default:       nxt_ctrl  = ctrl_ff;
      endcase
    end
    // clear only the bits that were reported, so an event after the setup edge survives
    if (rd_en && paddr == `OFS_IRQ_STAT) begin
      nxt_istat = istat_ff & ~prdata_ff[3:0];
    end
    nxt_istat[`ST_VALID_BIT] = nxt_istat[`ST_VALID_BIT] | ev_valid;
    nxt_istat[`ST_RANGE_BIT] = nxt_istat[`ST_RANGE_BIT] | ev_range;
    nxt_istat[`ST_WAKE_BIT]  = nxt_istat[`ST_WAKE_BIT]  | ev_wake;
    nxt_istat[`ST_DCS_BIT]   = nxt_istat[`ST_DCS_BIT]   | ev_dcs;
  end

  // all state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff       <= `CTRL_RESET;
      istat_ff      <= `IRQ_NONE;
      imask_ff      <= `IRQ_NONE;
      prdata_ff     <= 32'h0;
      pslverr_ff    <= 1'b0;
      op_ff         <= OP_NORMAL;
      valid_ff      <= 1'b1;
      wake_pend_ff  <= 1'b0;
      half_ff       <= 1'b0;
      word_ff       <= `CODE_MID;
      flag_ff       <= 1'b0;
      dcs_prev_ff   <= 1'b0;
      range_prev_ff <= 1'b0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      istat_ff      <= nxt_istat;
      imask_ff      <= nxt_imask;
      prdata_ff     <= nxt_prdata;
      pslverr_ff    <= nxt_pslverr;
      op_ff         <= nxt_op;
      valid_ff      <= nxt_valid;
      wake_pend_ff  <= nxt_wake_pend;
      half_ff       <= nxt_half;
      word_ff       <= nxt_word;
      flag_ff       <= nxt_flag;
      dcs_prev_ff   <= dcs_on;
      range_prev_ff <= pipe_flag;
    end
  end

  // drivers off whenever drive control is high or the core is powered down
  assign out_enable          = !drive_off_n && (op_ff == OP_NORMAL);
  assign sample_word         = word_ff;
  assign range_exceeded_flag = flag_ff;
  assign data_valid          = valid_ff && !rec.busy;
  assign internal_clk_half   = half_ff;
  assign irq                 = |(istat_ff & imask_ff);

  // assertions
  AST_CLAMP_POS: assert property (@(posedge pclk) disable iff (!presetn)
    core_over |-> clamp_word == 14'h3fff) else $error("over range not clamped");
  AST_CLAMP_NEG: assert property (@(posedge pclk) disable iff (!presetn)
    (core_under && !core_over) |-> clamp_word == 14'h0000)
    else $error("under range not clamped");
  AST_TWOS: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff == OP_NORMAL && fmt_twos) |=> word_ff == {~$past(pipe_word[13]), $past(pipe_word[12:0])})
    else $error("twos format wrong");
  AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff == OP_NORMAL && !fmt_twos) |=> word_ff == $past(pipe_word))
    else $error("offset format wrong");
  AST_OE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    drive_off_n |-> !out_enable) else $error("outputs driven while disabled");
  AST_PD_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff != OP_NORMAL) |-> !out_enable && !data_valid)
    else $error("outputs live in power down");
  AST_NAP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff == OP_NORMAL && pd_req && !drive_off_n) |=> op_ff == OP_NAP)
    else $error("nap not entered");
  AST_SLEEP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff == OP_NORMAL && pd_req && drive_off_n) |=> op_ff == OP_SLEEP)
    else $error("sleep not entered");
  AST_NAP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff == OP_NAP && !pd_req) |=> !data_valid [*8])
    else $error("data valid too soon after nap");
  AST_HALF: assert property (@(posedge pclk) disable iff (!presetn)
    (dcs_on && $past(dcs_on)) |-> half_ff != $past(half_ff))
    else $error("internal half clock stuck");
  AST_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    (op_ff != OP_NORMAL && !pd_req) |=> op_ff == OP_NORMAL)
    else $error("normal not resumed");

endmodule : adc_out_ctrl

/* verif/capture_latch.sv */
module capture_latch
  import adc_out_pkg::*;
(
  // clock
  input  wire logic    pclk,
  // pins from the converter
  input  wire sample_t sample_word,
  input  wire logic    range_exceeded_flag,
  input  wire logic    out_enable,
  input  wire logic    data_valid,
  // levels seen on the wires and the last captured pair
  output sample_t      pin_word,
  output logic         pin_flag,
  output logic [14:0]  cap_ff
);
  timeunit 1ns;
  timeprecision 1ns;

  sample_t last_word;
  logic    last_flag;

  // no pull on these pins, so a released wire shows the inverse of its last level
  always_comb begin
    pin_word = out_enable ? sample_word : ~last_word;
    pin_flag = out_enable ? range_exceeded_flag : ~last_flag;
  end

  // word and flag are taken on one edge; recovery words are dropped
  always @(posedge pclk) begin
    if (out_enable) begin
      last_word <= sample_word;
      last_flag <= range_exceeded_flag;
    end
    if (out_enable && data_valid) begin
      cap_ff <= {pin_flag, pin_word};
    end
  end
endmodule : capture_latch

/* verif/adc_sample_output_control_bench.sv */
`include "adc_out_defs.svh"

module adc_sample_output_control_bench
  import adc_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LAT = 3;
  localparam int SLP = 50;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] core_value = 15'h0;
  logic        core_over = 1'b0;
  logic        core_under = 1'b0;
  sample_t     sample_word;
  sample_t     pin_word;
  logic        range_exceeded_flag;
  logic        pin_flag;
  logic        out_enable;
  logic        data_valid;
  logic        internal_clk_half;
  logic        irq;
  logic [31:0] seed = 32'h781576d8;
  logic [31:0] r0;
  logic [14:0] q[$];
  logic [1:0]  mode = 2'h0;
  logic        chk = 1'b0;
  logic        no_rng = 1'b0;
  logic        ich_prev;
  logic [31:0] r;
  logic        e;
  int          c;
  int          errors = 0;
  int          tests_run = 0;

  // 10 MHz clock, inside the 1 to 25 Msps band at even duty
  always #50 pclk = ~pclk;

  adc_out_ctrl #(.LATENCY(LAT), .SLEEP_WAKE_CYC(SLP)) u_adc_out_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_value(core_value), .core_over(core_over), .core_under(core_under),
    .sample_word(sample_word), .range_exceeded_flag(range_exceeded_flag),
    .out_enable(out_enable), .data_valid(data_valid),
    .internal_clk_half(internal_clk_half), .irq(irq)
  );

  capture_latch u_capture_latch (
    .pclk(pclk), .sample_word(sample_word), .range_exceeded_flag(range_exceeded_flag),
    .out_enable(out_enable), .data_valid(data_valid), .pin_word(pin_word),
    .pin_flag(pin_flag), .cap_ff()
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [14:0] expv(logic [13:0] v, logic ov, logic un);
    logic [13:0] w;
    w = ov ? `CODE_POS_FS : (un ? `CODE_NEG_FS : v);
    if (mode[1]) begin
      w[13] = ~w[13];
    end
    return {ov | un, w};
  endfunction : expv

  task automatic check(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", s, x, g);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // one transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // counts edges until valid is seen high; the value at the calling edge is stale
  task automatic waitv();
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (data_valid !== 1'b1 && c < 1000);
    check("valid wait", 1, data_valid);
  endtask : waitv

  task automatic run(input logic [1:0] m);
    chk = 1'b0;
    mode = m;
    wr(`OFS_CTRL, {30'h0, m});
    q.delete();
    waitv();
    if (m == 2'h1) begin
      check("relock", 1, c >= 97 && c <= 103);
    end
    repeat (LAT + 3) @(posedge pclk);
    chk = 1'b1;
    repeat (60) @(posedge pclk);
    chk = 1'b0;
    rd(`OFS_STATUS);
    check("stab", m == 2'h1 || m == 2'h2, r[3]);
    check("op", 0, r[5:4]);
  endtask : run

  // random core results; expectation formed from the pre-edge inputs
  always @(posedge pclk) begin
    q.push_front(expv(core_value[13:0], core_over, core_under));
    if (q.size() > 16) begin
      void'(q.pop_back());
    end
    r0 = rnd();
    core_value <= r0[14:0];
    core_over <= !no_rng && r0[18:16] == 3'h0;
    core_under <= !no_rng && r0[21:19] == 3'h0;
  end

  // pins compared where settled, mid cycle
  always @(negedge pclk) begin
    if (chk && data_valid && q.size() > LAT) begin
      check("word", q[LAT][13:0], pin_word);
      check("flag", q[LAT][14], pin_flag);
      check("half", (mode == 2'h1 || mode == 2'h2) & ~ich_prev, internal_clk_half);
    end
    ich_prev = internal_clk_half;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL);
    check("ctrl rst", `CTRL_RESET, r);
    check("oe rst", 0, out_enable);
    wr(`OFS_IRQ_MASK, 32'h2);
    run(2'h0);
    check("irq", 1, irq);
    no_rng = 1'b1;
    repeat (LAT + 4) @(posedge pclk);
    rd(`OFS_IRQ_STAT);
    check("stat", 1, r[1]);
    rd(`OFS_IRQ_STAT);
    check("stat clr", 0, r[1]);
    check("irq clr", 0, irq);
    no_rng = 1'b0;
    rd(12'h020);
    check("slverr", 1, e);
    run(2'h1);
    rd(`OFS_IRQ_STAT);
    check("events", 4'hd, r[3:0] & 4'hd);
    // nap pulse longer than 1 us while the stabilizer is in use
    wr(`OFS_CTRL, 32'h5);
    // nap is entered one edge after the write, so look once it has settled
    @(negedge pclk);
    check("oe nap", 0, out_enable);
    @(posedge pclk);
    rd(`OFS_STATUS);
    check("op nap", 1, r[5:4]);
    repeat (`PD_PULSE_CYC + 2) @(posedge pclk);
    wr(`OFS_CTRL, 32'h1);
    waitv();
    check("nap wake", 1, c >= 97 && c <= 103);
    run(2'h2);
    run(2'h3);
    wr(`OFS_CTRL, 32'hc);
    check("oe sleep", 0, out_enable);
    rd(`OFS_STATUS);
    check("op sleep", 2, r[5:4]);
    wr(`OFS_CTRL, 32'h0);
    waitv();
    check("sleep wake", 1, c >= SLP - 3 && c <= SLP + 3);
    wr(`OFS_CTRL, 32'h8);
    check("oe drv", 0, out_enable);
    check("valid drv", 1, data_valid);
    wr(`OFS_IRQ_MASK, 32'h0);
    check("irq mask", 0, irq);
    final_report();
  end
endmodule : adc_sample_output_control_bench
